// >>> rtl/rlc_map.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef RLC_MAP_SVH
`define RLC_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define RLC_WAKE_OFS 8'h00
`define RLC_LV_OFS 8'h01

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RLC_WFLAG_BIT 7
`define RLC_WACK_BIT 6
`define RLC_WCLK_BIT 5
`define RLC_WIE_BIT 4
`define RLC_WDLY_HI 2
`define RLC_WDLY_LO 0
`define RLC_LFLAG_BIT 7
`define RLC_LACK_BIT 6
`define RLC_LIE_BIT 5
`define RLC_LRE_BIT 4
`define RLC_LSE_BIT 3
`define RLC_LDE_BIT 2
`define RLC_LRSV_BIT 1
`define RLC_LBG_BIT 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RLC_WAKE_RST 8'h00
`define RLC_LV_RST 8'h1C

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RLC_MCLK_NS 4
`define RLC_OSC_NS 1000000
`define RLC_OSC_CYC (`RLC_OSC_NS / `RLC_MCLK_NS)
`define RLC_INT_D1_MS 8
`define RLC_INT_D2_MS 32
`define RLC_INT_D3_MS 64
`define RLC_INT_D4_MS 128
`define RLC_INT_D5_MS 256
`define RLC_INT_D6_MS 512
`define RLC_INT_D7_MS 1024
`define RLC_EXT_D1 256
`define RLC_EXT_D2 1024
`define RLC_EXT_D3 2048
`define RLC_EXT_D4 4096
`define RLC_EXT_D5 8192
`define RLC_EXT_D6 16384
`define RLC_EXT_D7 32768

`endif

// >>> rtl/rlc_pkg.sv
// types shared by the system control block
package rlc_pkg;
  typedef enum logic [0:0] {
    RLC_SRC_OSC = 1'b0,
    RLC_SRC_EXT = 1'b1
  } rlc_src_t;
  typedef logic [2:0] rlc_dly_t;
  typedef logic [7:0] rlc_byte_t;
  typedef logic [14:0] rlc_cnt_t;
endpackage

// >>> rtl/rlc_sysctl.sv
// wakeup timer and low-voltage detect control registers
//
// Functional notes
// - timer reaching selected delay sets read-only wakeup flag, bit 7
// - writing 1 to ack bit 6 clears wakeup flag; 0 ignored; reads 0
// - clock select bit 5: 0 internal 1 kHz tick, 1 external clock
// - wakeup interrupt enable bit 4 is read/write, gates wakeup requests
// - delay select 000 stops the wakeup timer for either source
// - internal codes 001..111 give 8,32,64,128,256,512,1024 ms
// - external codes 001..111 divide by 256 up to 32768
// - unused wakeup register bit 3, the only unused bit, reads 0
// - internal wakeup tick is free running, about 1 kHz
// - enabled detection sets read-only low-voltage flag on an event
// - writing 1 to low-voltage ack bit 6 clears the flag; reads 0
// - irq enable bit 5 requests an interrupt while the flag is 1
// - reset enable bit 4 with detection on forces reset on flag
// - stop enable bit 3 keeps detection running in stop mode
// - enable bit 2 off makes flag, reset and stop controls inert
// - reset, stop and detect enables take only first write after reset
// - bandgap buffer enable bit 0 drives the buffer enable output
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "rlc_map.svh"
module rlc_sysctl #(
  parameter int unsigned OSC_CYC = `RLC_OSC_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output var logic [7:0] rdata,
  input wire logic ext_clk,
  input wire logic lv_detect,
  input wire logic stop_mode,
  output var logic wake_irq,
  output var logic lv_irq,
  output var logic lv_reset_req,
  output var logic bandgap_buf_en
);

  // reset image of the low-voltage register, sliced per field below
  localparam rlc_pkg::rlc_byte_t LV_RST = `RLC_LV_RST;

  // --------------------------------------------------------------------
  // delay lookup
  // --------------------------------------------------------------------
  function automatic rlc_pkg::rlc_cnt_t term_f(
    input rlc_pkg::rlc_src_t src,
    input rlc_pkg::rlc_dly_t sel
  );
    int unsigned n;
    n = 1;
    if (src == rlc_pkg::RLC_SRC_OSC) begin
      case (sel)
        3'h1: n = `RLC_INT_D1_MS;
        3'h2: n = `RLC_INT_D2_MS;
        3'h3: n = `RLC_INT_D3_MS;
        3'h4: n = `RLC_INT_D4_MS;
        3'h5: n = `RLC_INT_D5_MS;
        3'h6: n = `RLC_INT_D6_MS;
        3'h7: n = `RLC_INT_D7_MS;
        default: n = 1;
      endcase
    end else begin
      case (sel)
        3'h1: n = `RLC_EXT_D1;
        3'h2: n = `RLC_EXT_D2;
        3'h3: n = `RLC_EXT_D3;
        3'h4: n = `RLC_EXT_D4;
        3'h5: n = `RLC_EXT_D5;
        3'h6: n = `RLC_EXT_D6;
        3'h7: n = `RLC_EXT_D7;
        default: n = 1;
      endcase
    end
    return 15'(n - 1);
  endfunction

  // --------------------------------------------------------------------
  // register decode
  // --------------------------------------------------------------------
  logic wake_sel;
  logic lv_sel;
  logic wr_wake;
  logic wr_lv;
  logic rd_wake;
  logic rd_lv;

  assign wake_sel = (addr == `RLC_WAKE_OFS);
  assign lv_sel = (addr == `RLC_LV_OFS);
  assign wr_wake = wr_en & wake_sel;
  assign wr_lv = wr_en & lv_sel;
  assign rd_wake = rd_en & wake_sel;
  assign rd_lv = rd_en & lv_sel;

  // --------------------------------------------------------------------
  // wakeup timer state
  // --------------------------------------------------------------------
  logic wake_flag_q;
  logic wake_flag_d;
  rlc_pkg::rlc_src_t wake_clock_sel_q;
  logic wake_irq_en_q;
  rlc_pkg::rlc_dly_t wake_delay_sel_q;
  rlc_pkg::rlc_cnt_t cnt_q;
  rlc_pkg::rlc_cnt_t cnt_d;
  rlc_pkg::rlc_cnt_t term;
  logic ext_q;
  logic ext_rise;
  logic osc_tick;
  logic tick;
  logic run;
  logic wake_hit;
  logic wake_ack;

  // free-running internal 1 kHz tick, independent of the register state
  rlc_tick_div #(
    .PERIOD(OSC_CYC)
  ) u_osc (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(osc_tick)
  );

  assign ext_rise = ext_clk & ~ext_q;
  assign tick = (wake_clock_sel_q == rlc_pkg::RLC_SRC_EXT) ?
                ext_rise : osc_tick;
  assign run = (wake_delay_sel_q != 3'h0);
  assign term = term_f(wake_clock_sel_q, wake_delay_sel_q);
  // >= keeps the timer from running past a delay shortened mid-count
  assign wake_hit = run & tick & (cnt_q >= term);
  assign cnt_d = !run ? 15'h0000 :
                 wake_hit ? 15'h0000 :
                 tick ? cnt_q + 15'h0001 : cnt_q;
  assign wake_ack = wr_wake & wdata[`RLC_WACK_BIT];
  // a timeout in the same cycle as the ack wins
  assign wake_flag_d = wake_hit | (wake_flag_q & ~wake_ack);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= 1'b0;
      cnt_q <= 15'h0000;
      wake_flag_q <= 1'b0;
    end else begin
      ext_q <= ext_clk;
      cnt_q <= cnt_d;
      wake_flag_q <= wake_flag_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_clock_sel_q <= rlc_pkg::RLC_SRC_OSC;
      wake_irq_en_q <= 1'b0;
      wake_delay_sel_q <= 3'h0;
    end else if (wr_wake) begin
      wake_clock_sel_q <= rlc_pkg::rlc_src_t'(wdata[`RLC_WCLK_BIT]);
      wake_irq_en_q <= wdata[`RLC_WIE_BIT];
      wake_delay_sel_q <= wdata[`RLC_WDLY_HI:`RLC_WDLY_LO];
    end
  end

  // --------------------------------------------------------------------
  // low-voltage detect state
  // --------------------------------------------------------------------
  logic lv_flag_q;
  logic lv_flag_d;
  logic lv_irq_en_q;
  logic lv_reset_en_q;
  logic lv_stop_en_q;
  logic lv_detect_en_q;
  logic bg_q;
  logic once_q;
  logic lv_active;
  logic lv_set;
  logic lv_ack;
  logic once_wr;

  assign lv_active = lv_detect_en_q &
                     (~stop_mode | lv_stop_en_q);
  assign lv_set = lv_active & lv_detect;
  assign lv_ack = wr_lv & wdata[`RLC_LACK_BIT];
  assign lv_flag_d = lv_set | (lv_flag_q & ~lv_ack);
  assign once_wr = wr_lv & ~once_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lv_flag_q <= 1'b0;
      once_q <= 1'b0;
    end else begin
      lv_flag_q <= lv_flag_d;
      once_q <= once_q | wr_lv;
    end
  end

  // reserved bit 1 is not stored, whatever software writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lv_irq_en_q <= LV_RST[`RLC_LIE_BIT];
      bg_q <= LV_RST[`RLC_LBG_BIT];
    end else if (wr_lv) begin
      lv_irq_en_q <= wdata[`RLC_LIE_BIT];
      bg_q <= wdata[`RLC_LBG_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lv_reset_en_q <= LV_RST[`RLC_LRE_BIT];
      lv_stop_en_q <= LV_RST[`RLC_LSE_BIT];
      lv_detect_en_q <= LV_RST[`RLC_LDE_BIT];
    end else if (once_wr) begin
      lv_reset_en_q <= wdata[`RLC_LRE_BIT];
      lv_stop_en_q <= wdata[`RLC_LSE_BIT];
      lv_detect_en_q <= wdata[`RLC_LDE_BIT];
    end
  end

  // --------------------------------------------------------------------
  // read data and outputs
  // --------------------------------------------------------------------
  rlc_pkg::rlc_byte_t wake_rd;
  rlc_pkg::rlc_byte_t lv_rd;
  rlc_pkg::rlc_byte_t rd_mux;

  // ack bits and unused bits read as zero
  assign wake_rd = {wake_flag_q, 1'b0, wake_clock_sel_q,
                    wake_irq_en_q, 1'b0, wake_delay_sel_q};
  assign lv_rd = {lv_flag_q, 1'b0, lv_irq_en_q, lv_reset_en_q,
                  lv_stop_en_q, lv_detect_en_q, 1'b0, bg_q};
  assign rd_mux = rd_wake ? wake_rd :
                  rd_lv ? lv_rd : 8'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      wake_irq <= 1'b0;
      lv_irq <= 1'b0;
      lv_reset_req <= 1'b0;
      bandgap_buf_en <= 1'b0;
    end else begin
      rdata <= rd_mux;
      wake_irq <= wake_flag_q & wake_irq_en_q;
      lv_irq <= lv_flag_q & lv_irq_en_q;
      lv_reset_req <= lv_flag_q & lv_reset_en_q &
                      lv_detect_en_q;
      bandgap_buf_en <= bg_q;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wake_ack;
    wake_ack && !wake_hit;
  endsequence

  sequence s_lv_late_wr;
    wr_lv && once_q;
  endsequence

  sequence s_lv_clear;
    lv_ack && !lv_set;
  endsequence

  property p_wflag_set;
    wake_hit |=> wake_flag_q;
  endproperty
  a_wflag_set: assert property (p_wflag_set)
    else $error("wakeup flag not set on timeout");

  property p_wflag_ack;
    s_wake_ack |=> !wake_flag_q ##1 (!wake_flag_q || $past(wake_hit));
  endproperty
  a_wflag_ack: assert property (p_wflag_ack)
    else $error("wakeup ack did not clear flag");

  property p_wake_rd;
    rd_wake |=> (rdata[`RLC_WACK_BIT] == 1'b0) && (rdata[3] == 1'b0)
      && (rdata[`RLC_WFLAG_BIT] == $past(wake_flag_q));
  endproperty
  a_wake_rd: assert property (p_wake_rd)
    else $error("wakeup register read value wrong");

  property p_wake_off;
    (wake_delay_sel_q == 3'h0) && !wake_flag_q |=> !wake_flag_q
      && (cnt_q == 15'h0000);
  endproperty
  a_wake_off: assert property (p_wake_off)
    else $error("wakeup timer runs while disabled");

  property p_restart;
    wake_hit |=> (cnt_q == 15'h0000);
  endproperty
  a_restart: assert property (p_restart)
    else $error("timer did not restart after timeout");

  property p_wirq;
    (wake_flag_q && wake_irq_en_q) |=> wake_irq;
  endproperty
  a_wirq: assert property (p_wirq)
    else $error("wakeup irq missing");

  property p_wirq_off;
    !wake_irq_en_q |=> !wake_irq;
  endproperty
  a_wirq_off: assert property (p_wirq_off)
    else $error("wakeup irq while disabled");

  property p_lv_set;
    lv_set |=> lv_flag_q [*2] or (lv_flag_q ##1 $past(lv_ack));
  endproperty
  a_lv_set: assert property (p_lv_set)
    else $error("low-voltage flag not set");

  property p_lv_clear;
    s_lv_clear |=> !lv_flag_q;
  endproperty
  a_lv_clear: assert property (p_lv_clear)
    else $error("low-voltage ack did not clear flag");

  property p_lv_gate;
    !lv_detect_en_q |-> !lv_set ##1 !lv_reset_req;
  endproperty
  a_lv_gate: assert property (p_lv_gate)
    else $error("detection active while disabled");

  property p_lv_rst;
    (lv_flag_q && lv_reset_en_q && lv_detect_en_q) |=> lv_reset_req;
  endproperty
  a_lv_rst: assert property (p_lv_rst)
    else $error("low-voltage reset not requested");

  property p_once;
    s_lv_late_wr |=> $stable(lv_reset_en_q) && $stable(lv_stop_en_q)
      && $stable(lv_detect_en_q);
  endproperty
  a_once: assert property (p_once)
    else $error("write-once bits changed on a later write");

  property p_lv_irq;
    (lv_flag_q && lv_irq_en_q) |=> lv_irq;
  endproperty
  a_lv_irq: assert property (p_lv_irq)
    else $error("low-voltage irq missing");

endmodule
`default_nettype wire

// >>> rtl/rlc_tick_div.sv
// divider that gives a one-cycle tick every PERIOD clocks
`timescale 1ns/10ps
`default_nettype none
module rlc_tick_div #(
  parameter int unsigned PERIOD = 250000
) (
  input wire logic mclk,
  input wire logic rst_n,
  output var logic tick
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic last;

  assign last = (cnt_q == 32'(PERIOD - 1));
  assign cnt_d = last ? 32'h0000_0000 : cnt_q + 32'h0000_0001;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= last;
    end
  end
endmodule
`default_nettype wire

// >>> verification/rlc_sysctl_tb.sv
// self-checking testbench of the system control registers
`timescale 1ns/10ps
`default_nettype none
module rlc_sysctl_tb;
  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  localparam int OSC = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic ext_clk = 1'b0;
  logic lv_detect = 1'b0;
  logic stop_mode = 1'b0;
  logic [7:0] rdata;
  logic wake_irq;
  logic lv_irq;
  logic lv_reset_req;
  logic bandgap_buf_en;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int int_ms[7] = '{8, 32, 64, 128, 256, 512, 1024};
  int ext_div[3] = '{256, 1024, 2048};

  rlc_sysctl #(.OSC_CYC(OSC)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ext_clk(ext_clk),
    .lv_detect(lv_detect), .stop_mode(stop_mode), .wake_irq(wake_irq),
    .lv_irq(lv_irq), .lv_reset_req(lv_reset_req),
    .bandgap_buf_en(bandgap_buf_en)
  );

  initial begin
    forever #2 mclk = ~mclk;
  end

  // external clock runs free: one rising edge every two cycles
  always @(posedge mclk) begin
    ext_clk <= ~ext_clk;
    cyc <= cyc + 1;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic do_reset;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (wake_irq !== lvl && n < 10000);
    if (wake_irq !== lvl) begin
      error_cnt++;
      $display("Error at %0t: wakeup irq wait ran out", $time);
      finish_test();
    end
  endtask

  // time between two successive timeouts, in clocks
  task automatic period(input logic [7:0] ctl, input int exp);
    int t1;
    wr(8'h00, 8'h40);
    wr(8'h00, ctl);
    wait_irq(1'b1);
    t1 = cyc;
    wr(8'h00, ctl | 8'h40);
    wait_irq(1'b0);
    wait_irq(1'b1);
    check(cyc - t1, exp);
  endtask

  task automatic lv_pulse;
    @(posedge mclk);
    lv_detect <= 1'b1;
    @(posedge mclk);
    lv_detect <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic seen;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h1C);
    rd(8'h05, 8'h00);
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h37);
    wr(8'h00, 8'h50);
    seen = 1'b0;
    repeat (300) begin
      @(posedge mclk);
      #1;
      seen = seen | wake_irq;
    end
    check(seen, 1'b0);
    rd(8'h00, 8'h10);
    for (int i = 0; i < 7; i++) begin
      period(8'h10 | 8'(i + 1), int_ms[i] * OSC);
    end
    for (int i = 0; i < 3; i++) begin
      period(8'h30 | 8'(i + 1), ext_div[i] * 2);
    end
    wr(8'h00, 8'h61);
    repeat (600) @(posedge mclk);
    #1;
    check(wake_irq, 1'b0);
    rd(8'h00, 8'hA1);
    wr(8'h00, 8'h31);
    repeat (2) @(posedge mclk);
    #1;
    check(wake_irq, 1'b1);
    wr(8'h00, 8'h71);
    rd(8'h00, 8'h31);
    wr(8'h01, 8'h25);
    rd(8'h01, 8'h25);
    check(bandgap_buf_en, 1'b1);
    wr(8'h01, 8'h3C);
    rd(8'h01, 8'h24);
    check(bandgap_buf_en, 1'b0);
    lv_pulse();
    check({lv_irq, lv_reset_req}, 2'b10);
    rd(8'h01, 8'hA4);
    wr(8'h01, 8'h64);
    rd(8'h01, 8'h24);
    check(lv_irq, 1'b0);
    @(posedge mclk);
    stop_mode <= 1'b1;
    lv_pulse();
    rd(8'h01, 8'h24);
    do_reset();
    rd(8'h01, 8'h1C);
    wr(8'h01, 8'h3C);
    lv_pulse();
    check({lv_irq, lv_reset_req}, 2'b11);
    do_reset();
    wr(8'h01, 8'h38);
    lv_pulse();
    check({lv_irq, lv_reset_req}, 2'b00);
    wr(8'h01, 8'h3C);
    rd(8'h01, 8'h38);
    finish_test();
  end
endmodule
`default_nettype wire
